// file: core/tick_irq_ctrl.sv
`timescale 1ns/1ps

module tick_irq_ctrl #(
    parameter int PRESC_W = tick_irq_pkg::PRESC_W_DOC
) (
    input  wire logic                                  ref_clk,
    input  wire logic                                  rst,
    input  wire logic [tick_irq_pkg::ADDR_W-1:0]       paddr,
    input  wire logic                                  psel,
    input  wire logic                                  penable,
    input  wire logic                                  pwrite,
    input  wire logic [tick_irq_pkg::DATA_W-1:0]       pwdata,
    input  wire logic [3:0]                            pstrb,
    output logic      [tick_irq_pkg::DATA_W-1:0]       prdata,
    output logic                                       pready,
    output logic                                       pslverr,
    input  wire logic                                  sub_clk_pin,
    input  wire logic                                  hs_clk_pin,
    input  wire tick_irq_pkg::src_events_t             events,
    input  wire logic                                  stack_full,
    input  wire logic                                  irq_ack,
    input  wire logic                                  return_from_interrupt,
    output tick_irq_pkg::irq_out_t                     irq_o,
    output logic                                       wake_o
);

    // ------------------------------------------------------------------
    // Elaboration check
    // ------------------------------------------------------------------
    if (PRESC_W < tick_irq_pkg::PRESC_W_DOC) begin : g_bad_width
        $error("PRESC_W too small for the longest period");
    end

    localparam int N = tick_irq_pkg::NUM_SRC;

    logic [7:0]                       presc_src_r;
    logic [7:0]                       tick_ctrl_r;
    logic                             global_irq_enable_r;
    logic [N-1:0]                     en_r;
    logic [N-1:0]                     flags_r;
    logic [N-1:0]                     flags_nxt;
    logic [tick_irq_pkg::IDX_W-1:0]   idx_r;
    logic [tick_irq_pkg::IDX_W-1:0]   top_idx;
    logic                             req_r;
    logic [tick_irq_pkg::VEC_W-1:0]   vec_r;
    logic                             wake_r;
    logic [tick_irq_pkg::DATA_W-1:0]  prdata_r;
    logic [1:0]                       tick_ovf;

    // ------------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------------
    wire        setup_ph   = psel & ~penable;
    wire        access_ph  = psel & penable;
    wire        hit_presc  = (paddr == tick_irq_pkg::OFS_PRESC_SRC);
    wire        hit_tick   = (paddr == tick_irq_pkg::OFS_TICK_CTRL);
    wire        hit_gie    = (paddr == tick_irq_pkg::OFS_GLOBAL_EN);
    wire        hit_en     = (paddr == tick_irq_pkg::OFS_ENABLES);
    wire        hit_flags  = (paddr == tick_irq_pkg::OFS_FLAGS);
    wire        hit_status = (paddr == tick_irq_pkg::OFS_STATUS);
    wire        hit_any    = hit_presc | hit_tick | hit_gie | hit_en | hit_flags | hit_status;
    wire        wr_ok      = access_ph & pwrite & hit_any;
    wire [31:0] lane_mask  = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
    wire        presc_wr   = wr_ok & hit_presc & pstrb[0];
    wire        tick_wr    = wr_ok & hit_tick & pstrb[0];
    wire        gie_wr     = wr_ok & hit_gie & pstrb[0];
    wire        en_wr      = wr_ok & hit_en;
    wire        flag_wr    = wr_ok & hit_flags;
    wire [N-1:0] en_wval   = N'((pwdata & lane_mask) | (32'(en_r) & ~lane_mask));
    wire [N-1:0] flag_wval = N'((pwdata & lane_mask) | (32'(flags_r) & ~lane_mask));

    // Zero wait states; prdata is captured in the setup phase
    assign pready  = access_ph;
    assign pslverr = access_ph & ~hit_any;
    assign prdata  = prdata_r;

    wire [31:0] status_word = 32'({vec_r, 6'h00, global_irq_enable_r, req_r});
    wire [31:0] rd_data =
        hit_presc  ? 32'(presc_src_r & tick_irq_pkg::PRESC_SRC_MASK) :
        hit_tick   ? 32'(tick_ctrl_r) :
        hit_gie    ? 32'(global_irq_enable_r) :
        hit_en     ? 32'(en_r) :
        hit_flags  ? 32'(flags_r) :
        hit_status ? status_word : 32'h0000_0000;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            prdata_r <= 32'h0000_0000;
        end else if (setup_ph && !pwrite) begin
            prdata_r <= rd_data;
        end
    end

    // ------------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            presc_src_r <= tick_irq_pkg::PRESC_SRC_RST;
            tick_ctrl_r <= tick_irq_pkg::TICK_CTRL_RST;
            en_r        <= '0;
        end else begin
            if (presc_wr) begin
                presc_src_r <= pwdata[7:0] & tick_irq_pkg::PRESC_SRC_MASK;
            end
            if (tick_wr) begin
                tick_ctrl_r <= pwdata[7:0];
            end
            if (en_wr) begin
                en_r <= en_wval;
            end
        end
    end

    // ------------------------------------------------------------------
    // Prescaler clock sources
    // ------------------------------------------------------------------
    // Three-stage synchronisers; a level counts once stages two and three agree
    logic [2:0] sub_sync_r;
    logic [2:0] hs_sync_r;
    logic       sub_lvl_r;
    logic       hs_lvl_r;
    logic [tick_irq_pkg::SYS_DIV_W-1:0] div_r;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            sub_sync_r <= 3'h0;
            hs_sync_r  <= 3'h0;
            sub_lvl_r  <= 1'b0;
            hs_lvl_r   <= 1'b0;
            div_r      <= '0;
        end else begin
            sub_sync_r <= {sub_sync_r[1:0], sub_clk_pin};
            hs_sync_r  <= {hs_sync_r[1:0], hs_clk_pin};
            if (sub_sync_r[1] == sub_sync_r[2]) begin
                sub_lvl_r <= sub_sync_r[2];
            end
            if (hs_sync_r[1] == hs_sync_r[2]) begin
                hs_lvl_r <= hs_sync_r[2];
            end
            div_r <= div_r + 1'b1;
        end
    end

    // The high-speed source is only seen at up to a quarter of ref_clk
    wire sub_rise  = sub_sync_r[1] & sub_sync_r[2] & ~sub_lvl_r;
    wire hs_rise   = hs_sync_r[1] & hs_sync_r[2] & ~hs_lvl_r;
    wire div4_tick = &div_r;

    // ------------------------------------------------------------------
    // Tick generators
    // ------------------------------------------------------------------
    for (genvar g = 0; g < 2; g++) begin : g_tick
        localparam int SEL_LSB = (g == 0) ? tick_irq_pkg::TICK0_SEL_LSB : tick_irq_pkg::TICK1_SEL_LSB;
        localparam int PER_LSB = (g == 0) ? tick_irq_pkg::TICK0_PER_LSB : tick_irq_pkg::TICK1_PER_LSB;
        localparam int ON_BIT  = (g == 0) ? tick_irq_pkg::TICK0_ON_BIT : tick_irq_pkg::TICK1_ON_BIT;

        logic [PRESC_W-1:0] cnt_r;
        wire tick_irq_pkg::presc_src_t src =
            tick_irq_pkg::presc_src_t'(presc_src_r[SEL_LSB +: tick_irq_pkg::SEL_W]);
        wire [tick_irq_pkg::PER_W-1:0] per = tick_ctrl_r[PER_LSB +: tick_irq_pkg::PER_W];
        wire on = tick_ctrl_r[ON_BIT];
        wire presc_clock =
            (src == tick_irq_pkg::CLK_SYS)      ? 1'b1 :
            (src == tick_irq_pkg::CLK_SYS_DIV4) ? div4_tick :
            (src == tick_irq_pkg::CLK_SUB)      ? sub_rise : hs_rise;
        // Period 2^(8+per): overflow when the low 8+per bits are all ones
        wire [PRESC_W-1:0] per_mask =
            PRESC_W'(~({PRESC_W{1'b1}} << (tick_irq_pkg::PERIOD_EXP_MIN + int'(per))));

        always_ff @(posedge ref_clk) begin
            if (rst || !on) begin
                cnt_r <= '0;
            end else if (presc_clock) begin
                cnt_r <= cnt_r + 1'b1;
            end
        end

        assign tick_ovf[g] = on & presc_clock & ((cnt_r & per_mask) == per_mask);

        // Helper: cycles between overflows with a steady system-clock setup
        logic [PRESC_W:0] gap_r;
        logic             steady_r;
        always_ff @(posedge ref_clk) begin
            if (rst || presc_wr || tick_wr) begin
                gap_r    <= '0;
                steady_r <= 1'b0;
            end else if (tick_ovf[g]) begin
                gap_r    <= '0;
                steady_r <= (src == tick_irq_pkg::CLK_SYS);
            end else begin
                gap_r <= gap_r + 1'b1;
            end
        end

        chk_tick_period: assert property (@(posedge ref_clk) disable iff (rst)
            tick_ovf[g] && steady_r |-> int'(gap_r) == ((1 << (tick_irq_pkg::PERIOD_EXP_MIN + int'(per))) - 1))
            else $error("tick period does not match the selected time-out");
    end

    // ------------------------------------------------------------------
    // Request flags
    // ------------------------------------------------------------------
    wire [N-1:0] hw_set = {
        events.low_voltage,
        |events.uart_cond,
        events.nvm_write_done,
        events.i2c_addr_match | events.i2c_timeout | events.i2c_byte_done,
        tick_ovf[1],
        events.ptm_duty_match,
        events.ptm_period_match,
        events.ctm_duty_match,
        events.ctm_period_match,
        tick_ovf[0],
        events.touch_overflow,
        events.ext_edge
    };
    wire         served   = irq_ack & req_r;
    wire [N-1:0] ack_clr  = served ? (N'(1) << idx_r) : '0;

    // Hardware set wins over any clear; a service clear also wins over a software write
    assign flags_nxt = ((flag_wr ? flag_wval : flags_r) & ~ack_clr) | hw_set;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            flags_r <= '0;
            wake_r  <= 1'b0;
        end else begin
            flags_r <= flags_nxt;
            wake_r  <= |(flags_nxt & ~flags_r);
        end
    end
    assign wake_o = wake_r;

    // ------------------------------------------------------------------
    // Global enable
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            global_irq_enable_r <= 1'b0;
        end else if (return_from_interrupt) begin
            global_irq_enable_r <= 1'b1;
        end else if (served) begin
            global_irq_enable_r <= 1'b0;
        end else if (gie_wr) begin
            global_irq_enable_r <= pwdata[tick_irq_pkg::GLOBAL_EN_BIT];
        end
    end

    // ------------------------------------------------------------------
    // Priority and vector
    // ------------------------------------------------------------------
    wire [N-1:0] pend = flags_r & en_r;

    always_comb begin
        top_idx = '0;
        for (int i = N - 1; i >= 0; i--) begin
            if (pend[i]) begin
                top_idx = tick_irq_pkg::IDX_W'(i);
            end
        end
    end

    // Ack drops the request at once so a stale one is never offered twice
    wire req_nxt = global_irq_enable_r & (|pend) & ~stack_full & ~served;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            req_r <= 1'b0;
            idx_r <= '0;
            vec_r <= '0;
        end else begin
            req_r <= req_nxt;
            idx_r <= top_idx;
            vec_r <= tick_irq_pkg::VEC_BASE + tick_irq_pkg::VEC_W'(tick_irq_pkg::VEC_STEP * top_idx);
        end
    end

    // The core pushes only its program counter on ack; nothing else is saved here
    assign irq_o.req    = req_r;
    assign irq_o.vector = vec_r;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    chk_tick_sets_flag: assert property (@(posedge ref_clk) disable iff (rst)
        tick_ovf[0] |=> flags_r[tick_irq_pkg::SRC_TICK0])
        else $error("tick overflow did not set its flag");

    chk_req_gated: assert property (@(posedge ref_clk) disable iff (rst)
        irq_o.req |-> $past(global_irq_enable_r) && !$past(stack_full) && ($past(pend) != '0))
        else $error("request raised without enables or with full stack");

    chk_service_clears: assert property (@(posedge ref_clk) disable iff (rst)
        served && !return_from_interrupt && !hw_set[idx_r] |=> !global_irq_enable_r && !flags_r[$past(idx_r)])
        else $error("service did not clear flag and global enable");

    chk_presc_reserved: assert property (@(posedge ref_clk) disable iff (rst)
        setup_ph && !pwrite && hit_presc |=> (prdata[7:6] == 2'h0) && (prdata[3:2] == 2'h0))
        else $error("reserved prescaler source bits read nonzero");

    chk_tick_reset: assert property (@(posedge ref_clk) disable iff (rst)
        $fell(rst) |-> tick_ctrl_r == tick_irq_pkg::TICK_CTRL_RST && !tick_ovf[0] && !tick_ovf[1])
        else $error("tick control not cleared by reset");

    chk_serial_flag: assert property (@(posedge ref_clk) disable iff (rst)
        (|events.uart_cond) |=> flags_r[tick_irq_pkg::SRC_UART])
        else $error("serial-port condition did not set flag");

    chk_two_wire_flag: assert property (@(posedge ref_clk) disable iff (rst)
        events.i2c_timeout || events.i2c_addr_match || events.i2c_byte_done |=> flags_r[tick_irq_pkg::SRC_I2C])
        else $error("two-wire event did not set flag");

    chk_wake_rise: assert property (@(posedge ref_clk) disable iff (rst)
        (|(flags_r & ~$past(flags_r))) |-> wake_o)
        else $error("rising flag did not wake");

    chk_flag_held: assert property (@(posedge ref_clk) disable iff (rst)
        !served && !flag_wr |=> (flags_r & $past(flags_r)) == $past(flags_r))
        else $error("flag dropped without service or software clear");

    chk_return_sets: assert property (@(posedge ref_clk) disable iff (rst)
        return_from_interrupt |=> global_irq_enable_r ##1 1)
        else $error("return-from-interrupt did not set global enable");

    chk_lowest_first: assert property (@(posedge ref_clk) disable iff (rst)
        irq_o.req |-> ($past(pend) & ((N'(1) << $past(top_idx)) - N'(1))) == '0)
        else $error("lower vector pending but higher one chosen");

    chk_vector_value: assert property (@(posedge ref_clk) disable iff (rst)
        irq_o.req |-> int'(irq_o.vector) == 4 * (int'(idx_r) + 1))
        else $error("vector not at four-word spacing");

    chk_tick1_flag: assert property (@(posedge ref_clk) disable iff (rst)
        tick_ovf[1] |=> flags_r[tick_irq_pkg::SRC_TICK1])
        else $error("tick 1 overflow did not set its flag");

    chk_timer_flag: assert property (@(posedge ref_clk) disable iff (rst)
        events.ptm_period_match |=> flags_r[tick_irq_pkg::SRC_PTM_P])
        else $error("timer period match did not set its flag");

    chk_nvm_flag: assert property (@(posedge ref_clk) disable iff (rst)
        events.nvm_write_done |=> flags_r[tick_irq_pkg::SRC_NVM])
        else $error("nonvolatile write completion did not set its flag");

    chk_low_volt_flag: assert property (@(posedge ref_clk) disable iff (rst)
        events.low_voltage |=> flags_r[tick_irq_pkg::SRC_LVD])
        else $error("low supply did not set its flag");

    chk_touch_flag: assert property (@(posedge ref_clk) disable iff (rst)
        events.touch_overflow |=> flags_r[tick_irq_pkg::SRC_TOUCH])
        else $error("touch slot overflow did not set its flag");

    chk_gie_blocks: assert property (@(posedge ref_clk) disable iff (rst)
        !global_irq_enable_r |=> !irq_o.req)
        else $error("request raised while global enable low");

endmodule // tick_irq_ctrl

// file: core/tick_irq_pkg.sv
package tick_irq_pkg;

    // ------------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------------
    localparam int          ADDR_W        = 8;
    localparam int          DATA_W        = 32;
    localparam logic [7:0]  OFS_PRESC_SRC = 8'h00;
    localparam logic [7:0]  OFS_TICK_CTRL = 8'h04;
    localparam logic [7:0]  OFS_GLOBAL_EN = 8'h08;
    localparam logic [7:0]  OFS_ENABLES   = 8'h0C;
    localparam logic [7:0]  OFS_FLAGS     = 8'h10;
    localparam logic [7:0]  OFS_STATUS    = 8'h14;

    // ------------------------------------------------------------------
    // Reset values and field layout
    // ------------------------------------------------------------------
    localparam logic [7:0]  PRESC_SRC_RST  = 8'h00;
    localparam logic [7:0]  PRESC_SRC_MASK = 8'h33;
    localparam logic [7:0]  TICK_CTRL_RST  = 8'h00;
    localparam int          SEL_W          = 2;
    localparam int          PER_W          = 3;
    localparam int          TICK0_SEL_LSB  = 0;
    localparam int          TICK1_SEL_LSB  = 4;
    localparam int          TICK0_PER_LSB  = 0;
    localparam int          TICK1_PER_LSB  = 4;
    localparam int          TICK0_ON_BIT   = 3;
    localparam int          TICK1_ON_BIT   = 7;
    localparam int          PERIOD_EXP_MIN = 8;
    localparam int          PRESC_W_DOC    = 15;
    localparam int          SYS_DIV_W      = 2;
    localparam int          GLOBAL_EN_BIT  = 0;
    localparam int          STATUS_REQ_BIT = 0;
    localparam int          STATUS_GIE_BIT = 1;
    localparam int          STATUS_VEC_LSB = 8;

    // ------------------------------------------------------------------
    // Sources, in priority order (index 0 highest)
    // ------------------------------------------------------------------
    localparam int          NUM_SRC   = 12;
    localparam int          IDX_W     = 4;
    localparam int          VEC_W     = 6;
    localparam logic [5:0]  VEC_BASE  = 6'h04;
    localparam logic [5:0]  VEC_STEP  = 6'h04;
    localparam int          SRC_EXT   = 0;
    localparam int          SRC_TOUCH = 1;
    localparam int          SRC_TICK0 = 2;
    localparam int          SRC_CTM_P = 3;
    localparam int          SRC_CTM_A = 4;
    localparam int          SRC_PTM_P = 5;
    localparam int          SRC_PTM_A = 6;
    localparam int          SRC_TICK1 = 7;
    localparam int          SRC_I2C   = 8;
    localparam int          SRC_NVM   = 9;
    localparam int          SRC_UART  = 10;
    localparam int          SRC_LVD   = 11;
    localparam int          UART_COND_W = 6;

    typedef enum logic [1:0] {
        CLK_SYS,
        CLK_SYS_DIV4,
        CLK_SUB,
        CLK_HS
    } presc_src_t;

    typedef struct packed {
        logic                   ext_edge;
        logic                   touch_overflow;
        logic                   ctm_period_match;
        logic                   ctm_duty_match;
        logic                   ptm_period_match;
        logic                   ptm_duty_match;
        logic                   i2c_addr_match;
        logic                   i2c_timeout;
        logic                   i2c_byte_done;
        logic                   nvm_write_done;
        logic                   low_voltage;
        logic [UART_COND_W-1:0] uart_cond;
    } src_events_t;

    typedef struct packed {
        logic             req;
        logic [VEC_W-1:0] vector;
    } irq_out_t;

endpackage

// file: testbench/core_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Processor core stand-in: takes vectors, returns through return_from_interrupt
// ----------------------------------------------------------------
module core_model #(
    parameter int LAG = 2
) (
    input  wire logic                   ref_clk,
    input  wire logic                   rst,
    input  wire tick_irq_pkg::irq_out_t irq_in,
    output logic                        irq_ack,
    output logic                        return_from_interrupt = 1'b0,
    output logic [5:0]                  last_vec,
    output int                          acks
);
    int wait_cnt;
    // Waits LAG cycles before taking a request, so a slow core is covered
    always_ff @(posedge ref_clk) begin
        irq_ack <= 1'b0;
        if (rst) begin
            wait_cnt <= 0;
            acks     <= 0;
        end else if (irq_in.req && !irq_ack) begin
            if (wait_cnt == LAG) begin
                irq_ack  <= 1'b1;
                last_vec <= irq_in.vector;
                acks     <= acks + 1;
                wait_cnt <= 0;
            end else begin
                wait_cnt <= wait_cnt + 1;
            end
        end
    end
    task return_irq;
        @(posedge ref_clk) return_from_interrupt <= 1'b1;
        @(posedge ref_clk) return_from_interrupt <= 1'b0;
    endtask
endmodule // core_model

// file: testbench/testbench.sv
`timescale 1ns/1ps
module testbench;
    // ----------------------------------------------------------------
    // Signals
    // ----------------------------------------------------------------
    logic        ref_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
    logic        stack_full = 0, sub_clk_pin = 0, hs_clk_pin = 0;
    logic        pready, pslverr, irq_ack, rfi, wake_o, err;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic [16:0] ev = 17'h0;
    logic [5:0]  vec;
    int          error_cnt = 0, checks_done = 0, acks;
    int          fmap[17] = '{10, 10, 10, 10, 10, 10, 11, 9, 8, 8, 8, 6, 5, 4, 3, 1, 0};
    tick_irq_pkg::irq_out_t irq_o;
    initial forever #5 ref_clk = ~ref_clk;
    // Pin clocks move on clock edges: sub every 8 cycles, high-speed every 6
    initial forever begin
        repeat (4) @(posedge ref_clk);
        sub_clk_pin <= ~sub_clk_pin;
    end
    initial forever begin
        repeat (3) @(posedge ref_clk);
        hs_clk_pin <= ~hs_clk_pin;
    end
    tick_irq_ctrl uut (.ref_clk, .rst, .paddr, .psel, .penable, .pwrite, .pwdata, .pstrb(4'hF), .prdata,
        .pready, .pslverr, .sub_clk_pin, .hs_clk_pin, .events(tick_irq_pkg::src_events_t'(ev)),
        .stack_full, .irq_ack, .return_from_interrupt(rfi), .irq_o, .wake_o);
    core_model core (.ref_clk, .rst, .irq_in(irq_o), .irq_ack, .return_from_interrupt(rfi),
        .last_vec(vec), .acks);
    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge ref_clk) penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        @(posedge ref_clk);
    endtask
    task rd(input logic [7:0] a, input logic [31:0] e, input string nm);
        apb(1'b0, a, 32'h0);
        chk(nm, q, e);
    endtask
    // Flag write-back to zero between cases keeps each check independent
    task tick_case(input logic [31:0] ctrl, input logic [31:0] exp, input int n);
        apb(1'b1, tick_irq_pkg::OFS_FLAGS, 32'h0);
        apb(1'b1, tick_irq_pkg::OFS_TICK_CTRL, ctrl);
        repeat (n - 40) @(posedge ref_clk);
        rd(tick_irq_pkg::OFS_FLAGS, 32'h0, "tick_early");
        repeat (60) @(posedge ref_clk);
        rd(tick_irq_pkg::OFS_FLAGS, exp, "tick_late");
    endtask
    task pulse(input int k);
        ev <= 17'h1 << k;
        @(posedge ref_clk) ev <= 17'h0;
        @(posedge ref_clk);
    endtask
    task wrap_up;
        $display("Checks %0d, mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        #200000;
        error_cnt++;
        wrap_up;
    end
    // ----------------------------------------------------------------
    // Tests
    // ----------------------------------------------------------------
    initial begin
        repeat (4) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        rd(tick_irq_pkg::OFS_PRESC_SRC, 32'h0, "presc_rst");
        rd(tick_irq_pkg::OFS_TICK_CTRL, 32'h0, "tick_rst");
        apb(1'b1, tick_irq_pkg::OFS_PRESC_SRC, 32'hFF);
        rd(tick_irq_pkg::OFS_PRESC_SRC, 32'h33, "presc_mask");
        apb(1'b0, 8'h40, 32'h0);
        chk("unmapped_err", {31'h0, err}, 32'h1);
        $display("Registers done");
        apb(1'b1, tick_irq_pkg::OFS_PRESC_SRC, 32'h10);
        tick_case(32'h80, 32'h80, 1024);
        tick_case(32'h09, 32'h04, 512);
        apb(1'b1, tick_irq_pkg::OFS_FLAGS, 32'h0);
        repeat (500) @(posedge ref_clk);
        rd(tick_irq_pkg::OFS_FLAGS, 32'h4, "tick_again");
        apb(1'b1, tick_irq_pkg::OFS_TICK_CTRL, 32'h0);
        apb(1'b1, tick_irq_pkg::OFS_PRESC_SRC, 32'h32);
        tick_case(32'h88, 32'h80, 1536);
        repeat (520) @(posedge ref_clk);
        rd(tick_irq_pkg::OFS_FLAGS, 32'h84, "tick_sub_src");
        apb(1'b1, tick_irq_pkg::OFS_TICK_CTRL, 32'h0);
        apb(1'b1, tick_irq_pkg::OFS_FLAGS, 32'h0);
        $display("Tick generators done");
        for (int k = 0; k < 17; k++) begin
            pulse(k);
            chk("wake", {31'h0, wake_o}, 32'h1);
            rd(tick_irq_pkg::OFS_FLAGS, 32'h1 << fmap[k], "event_flag");
            apb(1'b1, tick_irq_pkg::OFS_FLAGS, 32'h0);
        end
        apb(1'b1, tick_irq_pkg::OFS_FLAGS, 32'h808);
        pulse(6);
        chk("wake_preset", {31'h0, wake_o}, 32'h0);
        rd(tick_irq_pkg::OFS_FLAGS, 32'h808, "flag_held");
        $display("Event sources done");
        apb(1'b1, tick_irq_pkg::OFS_ENABLES, 32'hFFF);
        stack_full <= 1'b1;
        apb(1'b1, tick_irq_pkg::OFS_GLOBAL_EN, 32'h1);
        repeat (8) @(posedge ref_clk);
        chk("stack_block", acks, 32'h0);
        stack_full <= 1'b0;
        repeat (10) @(posedge ref_clk);
        chk("vec_first", {26'h0, vec}, 32'h10);
        rd(tick_irq_pkg::OFS_FLAGS, 32'h800, "flag_cleared");
        rd(tick_irq_pkg::OFS_GLOBAL_EN, 32'h0, "gie_cleared");
        chk("no_nesting", acks, 32'h1);
        core.return_irq();
        repeat (10) @(posedge ref_clk);
        chk("vec_after_return_from_interrupt", {26'h0, vec}, 32'h30);
        chk("ack_count", acks, 32'h2);
        $display("Vectoring done");
        wrap_up;
    end
endmodule // testbench
